// *** src/twcp_port.sv ***
/*
 * two-wire command port with the start/stop/sleep control it steers.
 * link logic runs on the host serial clock; control runs on core_clk.
 * assumes the host keeps its own timing rules; rstn clears the link
 * asynchronously, without needing a serial clock falling edge.
 */
`timescale 1ns/100ps
`default_nettype none
module twcp_port
   import twcp_pkg::*;
#(
   parameter int MS_TICKS = MS_CYCLES
) (
   // core clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // serial link
   input wire logic serClk,
   input wire logic serDataIn,
   output logic serDataOut,
   output logic serDataOe,
   // configuration levels
   input wire logic txStartRising,
   input wire logic stopLongRange,
   input wire logic [2:0] stopStep,
   // status
   output logic edgeDetectEn,
   output logic txActive,
   output logic calibBusy,
   output logic sleeping
);
   // link domain, clocked on the serial clock falling edge
   logic [5:0] lowCnt_reg;
   logic inFrame_reg;
   logic [3:0] bitCnt_reg;
   logic [14:0] shift_reg;
   logic preamble_reg;
   logic [7:0] outShift_reg;
   logic oe_reg;
   logic portOff_reg;
   logic coreTog_reg;
   logic [7:0] regFile_reg [0:63];

   wire [15:0] frameWord = {shift_reg, serDataIn};
   wire frameEnd = inFrame_reg && (bitCnt_reg == LAST_BIT);
   wire [5:0] frameAddr = frameWord[ADDR_MSB:ADDR_LSB];
   wire [5:0] readAddr = {shift_reg[4:0], serDataIn};
   wire readStart = inFrame_reg && (bitCnt_reg == ADDR_LAST_BIT) && shift_reg[5]
      && !portOff_reg;
   wire isPortReset = frameEnd && preamble_reg && (frameWord == PORT_RESET_PAT);
   wire isRelease = frameEnd && !portOff_reg && (frameWord == PORT_RELEASE_PAT);
   wire isCoreReset = frameEnd && !portOff_reg && (frameWord == CORE_RESET_PAT);
   wire isWrite = frameEnd && !portOff_reg && !frameWord[RW_POS]
      && !isPortReset && !isRelease && !isCoreReset;
   wire [5:0] lowCntNext = (lowCnt_reg == PREAMBLE_FULL) ? lowCnt_reg
      : lowCnt_reg + 6'h0_001;

   // the link clock stops between frames, so reset here does not wait on it
   always_ff @(negedge serClk or negedge rstn) begin
      if (!rstn) begin
         lowCnt_reg <= 6'h0_000;
         inFrame_reg <= 1'b0;
         bitCnt_reg <= 4'h0_000;
         shift_reg <= 15'h0_000;
         preamble_reg <= 1'b0;
      end else if (!inFrame_reg) begin
         if (serDataIn) begin
            // every frame opens with a one
            inFrame_reg <= 1'b1;
            bitCnt_reg <= 4'h0_001;
            shift_reg <= 15'h0_001;
            preamble_reg <= (lowCnt_reg == PREAMBLE_FULL);
            lowCnt_reg <= 6'h0_000;
         end else begin
            lowCnt_reg <= lowCntNext;
         end
      end else begin
         shift_reg <= frameWord[14:0];
         bitCnt_reg <= bitCnt_reg + 4'h0_001;
         if (frameEnd) begin
            inFrame_reg <= 1'b0;
            preamble_reg <= 1'b0;
         end
      end
   end

   // read data leaves on the falls after the address byte
   always_ff @(negedge serClk or negedge rstn) begin
      if (!rstn) begin
         outShift_reg <= 8'h0_000;
         oe_reg <= 1'b0;
      end else if (readStart) begin
         outShift_reg <= regFile_reg[readAddr];
         oe_reg <= 1'b1;
      end else if (frameEnd) begin
         // releases before the last rise, well inside the idle limit
         oe_reg <= 1'b0;
      end else begin
         outShift_reg <= {outShift_reg[6:0], 1'b0};
      end
   end

   always_ff @(negedge serClk or negedge rstn) begin
      if (!rstn) begin
         portOff_reg <= PORT_OFF_RESET;
         coreTog_reg <= 1'b0;
      end else begin
         if (isPortReset) begin
            portOff_reg <= 1'b0;
         end else if (isRelease) begin
            portOff_reg <= 1'b1;
         end
         if (isCoreReset) begin
            coreTog_reg <= ~coreTog_reg;
         end
      end
   end

   // configuration bytes survive a core reset, only the port may change them
   always_ff @(negedge serClk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 64; i++) begin
            regFile_reg[i] <= REG_RESET_VAL;
         end
      end else if (isWrite) begin
         regFile_reg[frameAddr] <= frameWord[7:0];
      end
   end

   assign serDataOut = outShift_reg[7];
   assign serDataOe = oe_reg;

   // core domain
   logic [7:0] syncBus;
   logic dataPrev_reg;
   logic togPrev_reg;
   twcp_state_t state_reg;
   twcp_state_t state_next;
   logic [14:0] tickCnt_reg;
   logic [6:0] msCnt_reg;

   twcp_sync #(.WIDTH(8)) u_sync (
      .clk(core_clk),
      .rstn(rstn),
      .asyncIn({serDataIn, txStartRising, stopLongRange, stopStep, portOff_reg, coreTog_reg}),
      .syncOut(syncBus)
   );

   wire dataS = syncBus[7];
   wire risingMode = syncBus[6];
   wire longRange = syncBus[5];
   wire [2:0] stepS = syncBus[4:2];
   wire portOffS = syncBus[1];
   wire togS = syncBus[0];
   wire coreResetEv = togS ^ togPrev_reg;
   // rising mode idles low, falling mode idles high
   wire startEdge = risingMode ? (dataS && !dataPrev_reg) : (!dataS && dataPrev_reg);
   wire [6:0] stopBase = STOP_BASE_MS + {4'h0_000, stepS};
   wire [13:0] stopLong = stopBase * STOP_LONG_MULT;
   wire [6:0] stopTarget = longRange ? stopLong[6:0] : stopBase;
   wire msTick = (tickCnt_reg == 15'(MS_TICKS - 1));
   wire counting = (state_reg == ST_CALIB) || ((state_reg == ST_ACTIVE) && !dataS);
   wire stopDone = (state_reg == ST_ACTIVE) && (msCnt_reg == stopTarget);
   wire calibDone = (state_reg == ST_CALIB) && (msCnt_reg == CALIB_MS);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_SLEEP: begin
            // release must have settled a cycle, so the release frame's own
            // last data edge cannot race it into a start
            if (portOffS && edgeDetectEn && startEdge) begin
               state_next = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (stopDone) begin
               state_next = ST_SLEEP;
            end
         end
         ST_CALIB: begin
            if (calibDone) begin
               state_next = ST_SLEEP;
            end
         end
         default: state_next = ST_SLEEP;
      endcase
      if (coreResetEv) begin
         state_next = ST_CALIB;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         dataPrev_reg <= 1'b0;
         togPrev_reg <= 1'b0;
         state_reg <= ST_SLEEP;
      end else begin
         dataPrev_reg <= dataS;
         togPrev_reg <= togS;
         state_reg <= state_next;
      end
   end

   // data high or a state change restarts the window
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tickCnt_reg <= 15'h0_000;
         msCnt_reg <= 7'h0_000;
      end else if (!counting || (state_next != state_reg)) begin
         tickCnt_reg <= 15'h0_000;
         msCnt_reg <= 7'h0_000;
      end else if (msTick) begin
         tickCnt_reg <= 15'h0_000;
         msCnt_reg <= msCnt_reg + 7'h0_001;
      end else begin
         tickCnt_reg <= tickCnt_reg + 15'h0_001;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         edgeDetectEn <= 1'b0;
         txActive <= 1'b0;
         calibBusy <= 1'b0;
         sleeping <= 1'b1;
      end else begin
         edgeDetectEn <= portOffS;
         txActive <= (state_next == ST_ACTIVE);
         calibBusy <= (state_next == ST_CALIB);
         sleeping <= (state_next == ST_SLEEP);
      end
   end
endmodule // twcp_port
`default_nettype wire

// *** src/twcp_pkg.sv ***
/*
 * constants shared by the two-wire command port: command patterns, frame
 * layout, reset values and timing counts.
 * assumes a 25 MHz core clock.
 */
package twcp_pkg;
   // frame layout
   localparam int FRAME_BITS = 16;
   localparam logic [3:0] LAST_BIT = 4'h0_00F;
   localparam logic [3:0] ADDR_LAST_BIT = 4'h0_007;
   localparam int RW_POS = 14;
   localparam int ADDR_MSB = 13;
   localparam int ADDR_LSB = 8;
   localparam int PREAMBLE_LOWS = 32;
   localparam logic [5:0] PREAMBLE_FULL = 6'h0_020;
   // command patterns
   localparam logic [15:0] PORT_RESET_PAT = 16'h8D00;
   localparam logic [15:0] PORT_RELEASE_PAT = 16'h8D02;
   localparam logic [15:0] CORE_RESET_PAT = 16'hBD01;
   // reset values
   localparam logic [7:0] REG_RESET_VAL = 8'h0_000;
   localparam logic PORT_OFF_RESET = 1'b0;
   // timing
   localparam int CLK_NS = 40;
   localparam int MS_NS = 1_000_000;
   localparam int MS_CYCLES = MS_NS / CLK_NS;
   localparam logic [6:0] CALIB_MS = 7'h0_001;
   localparam logic [6:0] STOP_BASE_MS = 7'h0_002;
   localparam logic [6:0] STOP_LONG_MULT = 7'h0_00A;
   // core states
   typedef enum logic [1:0] {
      ST_SLEEP = 2'b00,
      ST_ACTIVE = 2'b01,
      ST_CALIB = 2'b10
   } twcp_state_t;
endpackage

// *** src/twcp_sync.sv ***
/*
 * two flip-flop synchroniser for a bundle of independent levels.
 * assumes each bit is a level that changes slowly against core_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module twcp_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // levels
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1_reg;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               stage1_reg[i] <= 1'b0;
               syncOut[i] <= 1'b0;
            end else begin
               stage1_reg[i] <= asyncIn[i];
               syncOut[i] <= stage1_reg[i];
            end
         end
      end
   endgenerate
endmodule // twcp_sync
`default_nettype wire

// *** verification/twcp_port_props.sv ***
/* checker for the status and link outputs of twcp_port.
   assumes MS_TICKS equals the parameter of the bound instance. */
`timescale 1ns/100ps
`default_nettype none
module twcp_port_props #(
   parameter int MS_TICKS = 25000
) (
   // clocks and reset
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic serClk,
   // link
   input wire logic serDataIn,
   input wire logic serDataOe,
   // status
   input wire logic edgeDetectEn,
   input wire logic txActive,
   input wire logic calibBusy,
   input wire logic sleeping
);
   logic [15:0] calCnt_reg;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) calCnt_reg <= 16'h0000;
      else calCnt_reg <= calibBusy ? calCnt_reg + 16'h0001 : 16'h0000;
   end
   AST_ONE_STATE: assert property (@(posedge core_clk) disable iff (!rstn)
      $onehot({txActive, calibBusy, sleeping})) else $error("state flags not one-hot");
   AST_CALIB_HOLD: assert property (@(posedge core_clk) disable iff (!rstn)
      $rose(calibBusy) |-> calibBusy [*8]) else $error("calibration too short");
   AST_CALIB_LEN: assert property (@(posedge core_clk) disable iff (!rstn)
      $fell(calibBusy) |-> calCnt_reg inside {[MS_TICKS-1:MS_TICKS+1]})
      else $error("calibration length wrong");
   AST_CALIB_SLEEP: assert property (@(posedge core_clk) disable iff (!rstn)
      $fell(calibBusy) |-> sleeping) else $error("no sleep after calibration");
   AST_TX_NEEDS_EDGE: assert property (@(posedge core_clk) disable iff (!rstn)
      $rose(txActive) |-> edgeDetectEn && $past(sleeping)) else $error("start while locked");
   AST_LOCKED: assert property (@(posedge core_clk) disable iff (!rstn)
      sleeping && !edgeDetectEn |=> !txActive) else $error("edge start while locked");
   AST_STOP_LOW: assert property (@(posedge core_clk) disable iff (!rstn)
      $fell(txActive) && sleeping |-> !$past(serDataIn, 4)) else $error("stop with data high");
   AST_READ_SPAN: assert property (@(negedge serClk) disable iff (!rstn)
      $rose(serDataOe) |-> serDataOe [*8] ##1 !serDataOe) else $error("read drive span wrong");
   AST_READ_LOCKED: assert property (@(negedge serClk) disable iff (!rstn)
      $rose(serDataOe) |-> !edgeDetectEn) else $error("read answered while released");
endmodule // twcp_port_props
`default_nettype wire

// *** verification/twcp_host_model.sv ***
/* host side of the two-wire link: clock, data drive and frames.
   assumes the bench calls its tasks one at a time. */
`timescale 1ns/100ps
`default_nettype none
module twcp_host_model (
   // link
   output logic serClk,
   output wire logic serDataIn,
   input wire logic serDataOut,
   input wire logic serDataOe,
   // idle data level
   input wire logic idleLvl
);
   logic hostD = 1'b1;
   logic hostOe = 1'b1;
   logic [7:0] q;
   initial serClk = 1'b1;
   // no pull on the line: a released line shows the inverse of the last drive
   assign serDataIn = serDataOe ? serDataOut : (hostOe ? hostD : ~hostD);
   task automatic cyc(input logic b, input logic drv, output logic s);
      hostOe = drv;
      if (drv) hostD = b;
      // falls land between core edges, away from core sampling
      #30 serClk = 1'b0;
      // 80 ns period keeps runs short; real hosts stay at 1 MHz or below
      #40 serClk = 1'b1;
      s = serDataIn;
      #10;
   endtask
   task automatic frame(input logic [15:0] w);
      logic s;
      for (int i = 0; i < 16; i++) begin
         cyc(w[15-i], !(w[14] && i >= 8), s);
         if (i >= 7 && i < 15) q = {q[6:0], s};
      end
      hostOe = 1'b1;
      hostD = idleLvl;
   endtask
   task automatic portRst();
      logic s;
      repeat (32) cyc(1'b0, 1'b1, s);
      frame(16'h8D00);
   endtask
   task automatic setLine(input logic v);
      hostD = v;
   endtask
endmodule // twcp_host_model
`default_nettype wire

// *** verification/twcp_port_tb.sv ***
/* self-checking bench for twcp_port with a host model on the link.
   assumes MS_TICKS is shortened to MST cycles. */
`timescale 1ns/100ps
`default_nettype none
module twcp_port_tb;
   import twcp_pkg::*;
   localparam int MST = 20;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic txStartRising = 1'b0;
   logic stopLongRange = 1'b0;
   logic [2:0] stopStep = 3'h0;
   wire logic serClk, serDataIn, serDataOut, serDataOe;
   wire logic edgeDetectEn, txActive, calibBusy, sleeping;
   int error_cnt = 0;
   int tests_run = 0;
   int cycles = 0;
   always #20 core_clk = ~core_clk;
   twcp_port #(.MS_TICKS(MST)) u_dut (.core_clk, .rstn, .serClk, .serDataIn, .serDataOut,
      .serDataOe, .txStartRising, .stopLongRange, .stopStep, .edgeDetectEn, .txActive,
      .calibBusy, .sleeping);
   twcp_host_model u_host (.serClk, .serDataIn, .serDataOut, .serDataOe,
      .idleLvl(~txStartRising));
   task automatic print_verdict();
      $display("mismatches %0d of %0d checks", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 6000) begin
         error_cnt++;
         print_verdict();
      end
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
         error_cnt++;
      end
   endtask
   function automatic logic stv(input int k);
      return k == 0 ? txActive : k == 1 ? calibBusy : sleeping;
   endfunction
   task automatic waitSt(input int k, input int lim);
      int n;
      n = 0;
      while (stv(k) !== 1'b1 && n < lim) begin
         @(negedge core_clk);
         n++;
      end
      check($sformatf("state %0d", k), {7'h00, stv(k)}, 8'h01);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      u_host.frame({2'b11, a, 8'h00});
      check("read data", u_host.q, exp);
   endtask
   task automatic s_power();
      u_host.portRst();
      u_host.frame(CORE_RESET_PAT);
      waitSt(1, 10);
      waitSt(2, MST + 10);
      check("edge enable", {7'h00, edgeDetectEn}, 8'h00);
   endtask
   task automatic s_regs();
      rd(6'h05, REG_RESET_VAL);
      u_host.frame(16'h92AA);
      rd(6'h12, 8'hAA);
      u_host.frame(16'h8D55);
      rd(6'h0D, 8'h55);
      u_host.frame(PORT_RESET_PAT);
      rd(6'h0D, 8'h00);
   endtask
   task automatic s_stop(input logic lng, input logic [2:0] stp);
      int e;
      @(negedge core_clk);
      stopLongRange = lng;
      stopStep = stp;
      e = (stp + 2) * (lng ? 10 : 1) * MST;
      u_host.portRst();
      u_host.frame(PORT_RELEASE_PAT);
      repeat (6) @(negedge core_clk);
      check("released", {7'h00, edgeDetectEn}, 8'h01);
      u_host.setLine(1'b0);
      waitSt(0, 10);
      repeat (e - 3) @(negedge core_clk);
      check("still sending", {7'h00, txActive}, 8'h01);
      waitSt(2, 8);
      // back to a locked sleep; the stop alone leaves edge detection enabled
      u_host.portRst();
      u_host.frame(CORE_RESET_PAT);
      waitSt(1, 10);
      waitSt(2, MST + 10);
      check("relocked", {7'h00, edgeDetectEn}, 8'h00);
   endtask
   task automatic s_after();
      @(negedge core_clk);
      txStartRising = 1'b1;
      // long window, so only the core reset can end this transmission
      stopLongRange = 1'b1;
      u_host.setLine(1'b0);
      u_host.portRst();
      u_host.frame(PORT_RELEASE_PAT);
      repeat (6) @(negedge core_clk);
      check("released", {7'h00, edgeDetectEn}, 8'h01);
      u_host.setLine(1'b1);
      waitSt(0, 10);
      u_host.portRst();
      repeat (6) @(negedge core_clk);
      check("locked", {7'h00, edgeDetectEn}, 8'h00);
      check("still active", {7'h00, txActive}, 8'h01);
      u_host.frame(CORE_RESET_PAT);
      waitSt(1, 10);
      waitSt(2, MST + 10);
      u_host.setLine(1'b1);
      repeat (10) @(negedge core_clk);
      check("no start", {7'h00, txActive}, 8'h00);
   endtask
   initial begin
      repeat (2) @(negedge core_clk);
      rstn = 1'b1;
      check("reset sleep", {7'h00, sleeping}, 8'h01);
      s_power();
      s_regs();
      s_stop(1'b0, 3'h7);
      s_stop(1'b1, 3'h0);
      s_after();
      print_verdict();
   end
endmodule // twcp_port_tb
bind twcp_port twcp_port_props #(.MS_TICKS(MS_TICKS)) u_props (.core_clk, .rstn, .serClk,
   .serDataIn, .serDataOe, .edgeDetectEn, .txActive, .calibBusy, .sleeping);
`default_nettype wire
